/* File: pkg/drs_pkg.sv */
// package: refresh and self-refresh constants and carrier types
package drs_pkg;
  localparam int ROW_W = 16;
  localparam logic [ROW_W-1:0] ROW_RST = 16'h0000;
  // internal refresh interval while in self-refresh, ns
  localparam int SR_TICK_NS = 7800;
  localparam int CLK_NS = 25;
  localparam int SR_TICK_CYC = (SR_TICK_NS + CLK_NS - 1) / CLK_NS;
  // refresh busy time, ns (tRFC, density dependent default)
  localparam int RFC_NS = 160;
  localparam int RFC_CYC = (RFC_NS + CLK_NS - 1) / CLK_NS;
  // dll relock time after exit, clock cycles
  localparam int DLL_LOCK_CYC = 512;
  localparam logic [15:0] CNT_ZERO = 16'h0000;

  // command pins as sampled, active low strobes plus active high cke
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
  } drs_cmd_t;

  typedef enum logic [1:0] {
    DRS_IDLE = 2'b00,
    DRS_REF = 2'b01,
    DRS_SREF = 2'b11,
    DRS_RELOCK = 2'b10
  } drs_state_t;
endpackage

/* File: src/drs_row_ctr.sv */
// module: internal refresh row address counter
`timescale 1ns/1ps
`default_nettype none
module drs_row_ctr #(
  parameter int W = drs_pkg::ROW_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic step,
  output logic [W-1:0] row
);
  // advance one row per refresh, wrap at the top
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      row <= drs_pkg::ROW_RST;
    end
    else if (step)
    begin
      row <= row + W'(1);
    end
  end
endmodule // drs_row_ctr
`default_nettype wire

/* File: src/drs_top.sv */
// module: dram-side refresh and self-refresh engine
// Behaviour
// - cs ras cas low, we high, cke high decodes a refresh.
// - rows come from internal counter; address ignored; banks left idle.
// - cs ras cas cke low, we high decodes self-refresh entry.
// - dll auto-disabled on entry, re-enabled with reset on exit when dll_on_mode is set.
// - in self-refresh only cke and reset matter; clock gated internally.
// - refresh within tCKE of entry, then timer-driven refreshes.
`timescale 1ns/1ps
`default_nettype none
module drs_top #(
  parameter int SR_TICK = drs_pkg::SR_TICK_CYC,
  parameter int ROW_W = drs_pkg::ROW_W
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire drs_pkg::drs_cmd_t cmd,
  input wire logic dll_on_mode,
  output logic refresh_busy,
  output logic refresh_pulse,
  output logic [ROW_W-1:0] refresh_row,
  output logic self_refresh,
  output logic dll_enable,
  output logic dll_reset,
  output logic clk_gate_off
);
  drs_pkg::drs_state_t state;
  logic [15:0] cnt;
  logic [15:0] tick;
  logic [ROW_W-1:0] row;
  logic step;
  logic dec_ref;
  logic dec_sre;
  logic dec_srx;
  logic first_done;

  // command decode from sampled pins
  assign dec_ref = state == drs_pkg::DRS_IDLE && !cmd.cs_n && !cmd.ras_n
    && !cmd.cas_n && cmd.we_n && cmd.cke;
  assign dec_sre = state == drs_pkg::DRS_IDLE && !cmd.cs_n && !cmd.ras_n
    && !cmd.cas_n && cmd.we_n && !cmd.cke;
  // only cke is looked at in self-refresh
  assign dec_srx = state == drs_pkg::DRS_SREF && cmd.cke;
  // one internal refresh right after entry, then on the timer
  assign step = dec_ref || (state == drs_pkg::DRS_SREF
    && (!first_done || tick == 16'(SR_TICK - 1)));

  // row counter, address bus never sampled
  drs_row_ctr #(.W(ROW_W)) u_row (
    .clk_sys(clk_sys),
    .rst(rst),
    .step(step),
    .row(row)
  );

  // main state sequence
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      state <= drs_pkg::DRS_IDLE;
      cnt <= drs_pkg::CNT_ZERO;
    end
    else
    begin
      case (state)
        drs_pkg::DRS_IDLE:
        begin
          if (dec_ref)
          begin
            state <= drs_pkg::DRS_REF;
            cnt <= 16'(drs_pkg::RFC_CYC - 1);
          end
          else if (dec_sre)
          begin
            state <= drs_pkg::DRS_SREF;
          end
        end
        drs_pkg::DRS_REF:
        begin
          if (cnt == drs_pkg::CNT_ZERO)
          begin
            state <= drs_pkg::DRS_IDLE;
          end
          else
          begin
            cnt <= cnt - 16'h0001;
          end
        end
        drs_pkg::DRS_SREF:
        begin
          if (dec_srx)
          begin
            state <= drs_pkg::DRS_RELOCK;
            cnt <= 16'(drs_pkg::DLL_LOCK_CYC - 1);
          end
        end
        drs_pkg::DRS_RELOCK:
        begin
          if (cnt == drs_pkg::CNT_ZERO)
          begin
            state <= drs_pkg::DRS_IDLE;
          end
          else
          begin
            cnt <= cnt - 16'h0001;
          end
        end
        default:
        begin
          state <= drs_pkg::DRS_IDLE;
        end
      endcase
    end
  end

  // self-refresh internal timer
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      tick <= drs_pkg::CNT_ZERO;
      first_done <= 1'b0;
    end
    else if (state != drs_pkg::DRS_SREF)
    begin
      tick <= drs_pkg::CNT_ZERO;
      first_done <= 1'b0;
    end
    else
    begin
      first_done <= 1'b1;
      if (tick == 16'(SR_TICK - 1))
      begin
        tick <= drs_pkg::CNT_ZERO;
      end
      else
      begin
        tick <= tick + 16'h0001;
      end
    end
  end

  // registered outputs
  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      refresh_busy <= 1'b0;
      refresh_pulse <= 1'b0;
      refresh_row <= drs_pkg::ROW_RST;
      self_refresh <= 1'b0;
      dll_enable <= 1'b0;
      dll_reset <= 1'b0;
      clk_gate_off <= 1'b0;
    end
    else
    begin
      refresh_pulse <= step;
      refresh_row <= row;
      refresh_busy <= dec_ref || (state == drs_pkg::DRS_REF
        && cnt != drs_pkg::CNT_ZERO);
      self_refresh <= dec_sre || (state == drs_pkg::DRS_SREF && !dec_srx);
      clk_gate_off <= dec_sre || (state == drs_pkg::DRS_SREF && !dec_srx);
      // dll off in self-refresh, reset pulse on exit when dll_on_mode is set
      dll_enable <= dll_on_mode && !dec_sre
        && !(state == drs_pkg::DRS_SREF && !dec_srx);
      dll_reset <= dll_on_mode && dec_srx;
    end
  end

  // first internal refresh shows one cycle after self_refresh rises
  sref_first_a: assert property (@(posedge clk_sys) disable iff (rst)
    dec_sre |=> self_refresh ##1 refresh_pulse)
    else $error("no refresh on self-refresh entry");
  ref_busy_a: assert property (@(posedge clk_sys) disable iff (rst)
    dec_ref |=> refresh_busy [*7] ##1 !refresh_busy)
    else $error("refresh busy length wrong");
  ref_row_a: assert property (@(posedge clk_sys) disable iff (rst)
    dec_ref |=> ##1 refresh_row == $past(refresh_row) + ROW_W'(1))
    else $error("row counter did not advance");
  sre_dll_a: assert property (@(posedge clk_sys) disable iff (rst)
    dec_sre |=> !dll_enable && clk_gate_off)
    else $error("dll not off in self-refresh");
  srx_dll_a: assert property (@(posedge clk_sys) disable iff (rst)
    dec_srx && dll_on_mode |=> dll_reset && dll_enable
      && !self_refresh)
    else $error("dll not reset on exit");
  srx_nodll_a: assert property (@(posedge clk_sys) disable iff (rst)
    dec_srx && !dll_on_mode |=> !dll_reset && !dll_enable)
    else $error("dll touched in dll-off mode");
  sr_ignore_a: assert property (@(posedge clk_sys) disable iff (rst)
    self_refresh && !cmd.cke |=> !refresh_busy)
    else $error("command taken in self-refresh");
  ref_decode_a: assert property (@(posedge clk_sys) disable iff (rst)
    state == drs_pkg::DRS_IDLE && !cmd.cs_n && !cmd.ras_n && !cmd.cas_n
      && cmd.we_n && cmd.cke |=> refresh_pulse && refresh_busy)
    else $error("refresh not decoded");
  sre_decode_a: assert property (@(posedge clk_sys) disable iff (rst)
    state == drs_pkg::DRS_IDLE && !cmd.cs_n && !cmd.ras_n && !cmd.cas_n
      && cmd.we_n && !cmd.cke |=> self_refresh)
    else $error("self-refresh entry not decoded");
  ref_cov_c: cover property (@(posedge clk_sys) dec_ref);
  sre_cov_c: cover property (@(posedge clk_sys) dec_sre);
  srx_cov_c: cover property (@(posedge clk_sys) dec_srx);
  srx_nodll_c: cover property (@(posedge clk_sys) dec_srx && !dll_on_mode);
endmodule // drs_top
`default_nettype wire

/* File: verif/drs_ctl_model.sv */
// partner model: controller issuing refresh and self-refresh commands
`timescale 1ns/1ps
`default_nettype none
module drs_ctl_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [1:0] op,
  output drs_pkg::drs_cmd_t cmd
);
  logic in_sr;
  logic [3:0] junk;
  // tracks self-refresh; scrambles pins the device must ignore
  always_ff @(posedge clk_sys)
  begin
    junk <= rst ? 4'h0 : junk + 4'h5;
    if (rst)
      in_sr <= 1'h0;
    else if (op == 2'h2)
      in_sr <= 1'h1;
    else if (op == 2'h3)
      in_sr <= 1'h0;
  end
  // op 0 nop, 1 refresh, 2 entry, 3 exit
  always_comb
  begin
    cmd = {4'h7, 1'h1};
    if (op == 2'h1)
      cmd = {4'h1, 1'h1};
    if (op == 2'h2)
      cmd = {4'h1, 1'h0};
    // pins scrambled while cke is held low
    if (in_sr)
      cmd = {junk, 1'h0};
    // exit: cke rises together with a plain nop
    if (in_sr && op == 2'h3)
      cmd = {4'h7, 1'h1};
  end
endmodule // drs_ctl_model
`default_nettype wire

/* File: verif/tb_top.sv */
// testbench: refresh, self-refresh and relock scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clk_sys;
  logic rst;
  logic [1:0] op;
  logic dll_on_mode;
  drs_pkg::drs_cmd_t cmd;
  logic refresh_busy;
  logic refresh_pulse;
  logic [15:0] refresh_row;
  logic self_refresh;
  logic dll_enable;
  logic dll_reset;
  logic clk_gate_off;
  int fails;
  int n_checks;
  int np;
  int nb;
  int nd;
  // clock source
  initial
  begin
    clk_sys = 1'h0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  drs_ctl_model model_u (.clk_sys(clk_sys), .rst(rst), .op(op), .cmd(cmd));
  drs_top #(.SR_TICK(8)) dut_u (.clk_sys(clk_sys), .rst(rst), .cmd(cmd),
    .dll_on_mode(dll_on_mode), .refresh_busy(refresh_busy),
    .refresh_pulse(refresh_pulse), .refresh_row(refresh_row),
    .self_refresh(self_refresh), .dll_enable(dll_enable),
    .dll_reset(dll_reset), .clk_gate_off(clk_gate_off));
  // pulse and busy tallies on settled values
  always @(negedge clk_sys)
  begin
    np += int'(refresh_pulse === 1'h1);
    nb += int'(refresh_busy === 1'h1);
    nd += int'(dll_reset === 1'h1);
  end
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic clr();
    np = 0;
    nb = 0;
    nd = 0;
  endtask
  task automatic issue(input logic [1:0] o);
    @(posedge clk_sys);
    op <= o;
    @(posedge clk_sys);
    op <= 2'h0;
  endtask
  // refresh, second one refused while busy
  task automatic ref_case();
    logic [15:0] r;
    r = refresh_row;
    clr();
    issue(2'h1);
    repeat (3) @(posedge clk_sys);
    issue(2'h1);
    repeat (12) @(posedge clk_sys);
    chk(16'(np), 16'h0001);
    chk(16'(nb), 16'(drs_pkg::RFC_CYC));
    chk(refresh_row, r + 16'h0001);
  endtask
  // entry, timer refreshes, exit
  task automatic sr_case();
    logic [15:0] r;
    r = refresh_row;
    clr();
    issue(2'h2);
    repeat (20) @(posedge clk_sys);
    chk({15'h0000, self_refresh}, 16'h0001);
    chk({15'h0000, clk_gate_off}, 16'h0001);
    chk({15'h0000, dll_enable}, 16'h0000);
    chk(16'(np), 16'h0003);
    chk(refresh_row, r + 16'h0003);
    clr();
    issue(2'h3);
    repeat (4) @(posedge clk_sys);
    chk({15'h0000, self_refresh}, 16'h0000);
    chk(16'(nd), 16'h0001);
    chk({15'h0000, dll_enable}, 16'h0001);
  endtask
  // refresh ignored during relock, accepted after it
  task automatic relock_case();
    clr();
    issue(2'h1);
    repeat (10) @(posedge clk_sys);
    chk(16'(np), 16'h0000);
    repeat (drs_pkg::DLL_LOCK_CYC) @(posedge clk_sys);
    ref_case();
  endtask
  // dll-off mode: re-entry and exit, no dll activity
  task automatic dll_off_case();
    dll_on_mode <= 1'h0;
    clr();
    issue(2'h2);
    repeat (8) @(posedge clk_sys);
    chk({15'h0000, self_refresh}, 16'h0001);
    chk({15'h0000, dll_enable}, 16'h0000);
    issue(2'h3);
    repeat (4) @(posedge clk_sys);
    chk({15'h0000, self_refresh}, 16'h0000);
    chk({15'h0000, dll_enable}, 16'h0000);
    chk(16'(nd), 16'h0000);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    rst = 1'h1;
    op = 2'h0;
    dll_on_mode = 1'h1;
    fails = 0;
    n_checks = 0;
    repeat (8) @(posedge clk_sys);
    chk({refresh_busy, refresh_pulse, self_refresh, dll_reset}, 16'h0000);
    rst <= 1'h0;
    ref_case();
    sr_case();
    relock_case();
    dll_off_case();
    final_report();
  end
  // hang guard, about 2000 cycles
  initial
  begin
    #50000;
    fails++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
